// *** clbc_pkg.sv ***
// Shared constants and types for the local bus control block.
package clbc_pkg;
  // Cycle kinds requested by the execution core.
  typedef enum logic [2:0] {
    CLBC_REQ_FETCH,
    CLBC_REQ_MEM_RD,
    CLBC_REQ_MEM_WR,
    CLBC_REQ_IO_RD,
    CLBC_REQ_IO_WR,
    CLBC_REQ_HALT,
    CLBC_REQ_SHUTDOWN,
    CLBC_REQ_INTA
  } clbc_req_t;

  localparam logic [1:0] CLBC_ST_INTA   = 2'h0;
  localparam logic [1:0] CLBC_ST_HALT   = 2'h0;
  localparam logic [1:0] CLBC_ST_READ   = 2'h1;
  localparam logic [1:0] CLBC_ST_WRITE  = 2'h2;
  localparam logic [1:0] CLBC_ST_IDLE   = 2'h3;
  localparam logic [1:0] CLBC_HALT_A1   = 2'h2;
  localparam logic [1:0] CLBC_SHUT_A1   = 2'h0;
  localparam int         CLBC_RST_MIN_CYC  = 16;
  localparam int         CLBC_INIT_CYC     = 50;
  localparam int         CLBC_NMI_LVL_CYC  = 4;
  localparam logic [7:0] CLBC_NMI_VECTOR   = 8'h02;
  localparam int         CLBC_INTA_CYCLES  = 2;
endpackage : clbc_pkg

// *** clbc_top.sv ***
// Local bus control: cycle status, lock, ready, hold, interrupts, coprocessor handshake.
`timescale 1ns/1ps
module clbc_top
  import clbc_pkg::*;
(
  input  wire logic       SYS_CLK,
  input  wire logic       RST,
  input  wire logic       CYC_REQ,
  input  wire clbc_req_t  CYC_KIND,
  input  wire logic       CYC_LOCKED,
  input  wire logic       CYC_OPERAND,
  output logic            CYC_DONE,
  input  wire logic       INT_ENABLE,
  input  wire logic       WAIT_INSTR,
  input  wire logic       INSTR_END_NEAR,
  output logic            INT_TAKE,
  output logic [7:0]      INT_VECTOR,
  output logic            INT_INTERNAL,
  output logic            EXEC_STALL,
  output logic            INIT_DONE,
  input  wire logic       READY_N,
  input  wire logic       BUS_REQUEST,
  input  wire logic       MASKABLE_IRQ,
  input  wire logic       NMI_REQUEST,
  input  wire logic       EXT_OPERAND_REQUEST,
  input  wire logic       COPRO_BUSY_N,
  input  wire logic       COPRO_ERROR_N,
  output logic            CYCLE_STATUS_HI_N,
  output logic            CYCLE_STATUS_HI_N_OE,
  output logic            CYCLE_STATUS_LO_N,
  output logic            CYCLE_STATUS_LO_N_OE,
  output logic            MEM_IO_SELECT,
  output logic            MEM_IO_SELECT_OE,
  output logic            FETCH_OR_INTACK_QUALIFIER,
  output logic            FETCH_OR_INTACK_QUALIFIER_OE,
  output logic            BUS_LOCK_N,
  output logic            BUS_LOCK_N_OE,
  output logic            EXT_OPERAND_ACK_N,
  output logic            EXT_OPERAND_ACK_N_OE,
  output logic            ADDR_A1,
  output logic            BUS_DRIVE_OE,
  output logic            BUS_GRANT_ACK
);
  typedef enum {CLBC_INIT, CLBC_IDLE, CLBC_STAT, CLBC_CMD, CLBC_FLOAT, CLBC_GRANT} clbc_state_t;

  // Two-flop synchronisers for every input from outside the clock domain.
  logic [6:0] sync1, sync2;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sync1 <= 7'h61;
      sync2 <= 7'h61;
    end else begin
      sync1 <= {COPRO_ERROR_N, COPRO_BUSY_N, EXT_OPERAND_REQUEST, NMI_REQUEST, MASKABLE_IRQ, BUS_REQUEST, READY_N};
      sync2 <= sync1;
    end
  end
  wire ready_n_s = sync2[0];
  wire hold_s    = sync2[1];
  wire irq_s     = sync2[2];
  wire nmi_s     = sync2[3];
  wire peq_s     = sync2[4];
  wire busy_n_s  = sync2[5];
  wire err_n_s   = sync2[6];

  function automatic logic [3:0] clbc_encode(input clbc_req_t k);
    // Returns {code qualifier, memory select, status pair}; reserved codes cannot arise.
    case (k)
      CLBC_REQ_INTA:     clbc_encode = {2'b00, CLBC_ST_INTA};
      CLBC_REQ_HALT:     clbc_encode = {2'b01, CLBC_ST_HALT};
      CLBC_REQ_SHUTDOWN: clbc_encode = {2'b01, CLBC_ST_HALT};
      CLBC_REQ_MEM_RD:   clbc_encode = {2'b01, CLBC_ST_READ};
      CLBC_REQ_MEM_WR:   clbc_encode = {2'b01, CLBC_ST_WRITE};
      CLBC_REQ_FETCH:    clbc_encode = {2'b11, CLBC_ST_READ};
      CLBC_REQ_IO_RD:    clbc_encode = {2'b10, CLBC_ST_READ};
      CLBC_REQ_IO_WR:    clbc_encode = {2'b10, CLBC_ST_WRITE};
      default:           clbc_encode = {2'b00, CLBC_ST_IDLE};
    endcase
  endfunction : clbc_encode

  clbc_state_t state, next_state;
  logic [5:0]  init_cnt, next_init_cnt;
  logic        phase, next_phase;
  logic [1:0]  status, next_status;
  logic        mio, next_mio, cod, next_cod, lock, next_lock, lock_hold, next_lock_hold;
  logic        a1, next_a1, ext_operand_ack_n, next_ext_operand_ack_n;

  always_comb begin
    next_state     = state;
    next_init_cnt  = init_cnt;
    next_phase     = ~phase;
    next_status    = CLBC_ST_IDLE;
    next_mio       = mio;
    next_cod       = cod;
    next_lock      = lock_hold;
    next_lock_hold = lock_hold;
    next_a1        = a1;
    next_ext_operand_ack_n     = 1'b1;
    CYC_DONE       = 1'b0;
    case (state)
      CLBC_INIT: begin
        next_init_cnt = init_cnt + 6'h01;
        if (init_cnt == 6'(CLBC_INIT_CYC - 1))
          next_state = CLBC_IDLE;
      end
      CLBC_IDLE: begin
        if (hold_s && !lock_hold) begin
          next_state = CLBC_FLOAT;
        end else if (CYC_REQ) begin
          {next_cod, next_mio, next_status} = clbc_encode(CYC_KIND);
          next_a1        = (CYC_KIND == CLBC_REQ_HALT) ? CLBC_HALT_A1[1] : CLBC_SHUT_A1[1];
          next_lock      = CYC_LOCKED || (CYC_KIND == CLBC_REQ_INTA);
          next_lock_hold = next_lock;
          next_ext_operand_ack_n     = ~CYC_OPERAND;
          next_state     = CLBC_STAT;
        end
      end
      CLBC_STAT: begin
        next_ext_operand_ack_n = ext_operand_ack_n;
        next_state = CLBC_CMD;
      end
      CLBC_CMD: begin
        next_ext_operand_ack_n = ext_operand_ack_n;
        if (!ready_n_s) begin
          CYC_DONE       = 1'b1;
          next_ext_operand_ack_n     = 1'b1;
          next_lock_hold = CYC_REQ && CYC_LOCKED;
          next_lock      = next_lock_hold;
          next_state     = CLBC_IDLE;
        end
      end
      CLBC_FLOAT: begin
        next_lock  = 1'b0;
        next_state = CLBC_GRANT;
      end
      CLBC_GRANT: begin
        next_lock = 1'b0;
        if (!hold_s)
          next_state = CLBC_IDLE;
      end
      default: next_state = CLBC_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state     <= CLBC_INIT;
      init_cnt  <= 6'h00;
      phase     <= 1'b0;
      status    <= CLBC_ST_IDLE;
      mio       <= 1'b0;
      cod       <= 1'b0;
      lock      <= 1'b0;
      lock_hold <= 1'b0;
      a1        <= 1'b1;
      ext_operand_ack_n     <= 1'b1;
    end else begin
      state     <= next_state;
      init_cnt  <= next_init_cnt;
      phase     <= next_phase;
      status    <= next_status;
      mio       <= next_mio;
      cod       <= next_cod;
      lock      <= next_lock;
      lock_hold <= next_lock_hold;
      a1        <= next_a1;
      ext_operand_ack_n     <= next_ext_operand_ack_n;
    end
  end

  wire granted = (state == CLBC_FLOAT) || (state == CLBC_GRANT);
  // Pins go undriven before the acknowledge rises, so another master never overlaps us.
  assign BUS_DRIVE_OE                 = !granted;
  assign CYCLE_STATUS_HI_N            = granted | status[1];
  assign CYCLE_STATUS_LO_N            = granted | status[0];
  assign CYCLE_STATUS_HI_N_OE         = !granted;
  assign CYCLE_STATUS_LO_N_OE         = !granted;
  assign MEM_IO_SELECT                = mio;
  assign MEM_IO_SELECT_OE             = !granted;
  assign FETCH_OR_INTACK_QUALIFIER    = cod;
  assign FETCH_OR_INTACK_QUALIFIER_OE = !granted;
  assign BUS_LOCK_N                   = granted | ~lock;
  assign BUS_LOCK_N_OE                = !granted;
  assign EXT_OPERAND_ACK_N            = granted | ext_operand_ack_n;
  assign EXT_OPERAND_ACK_N_OE         = !granted;
  assign ADDR_A1                      = a1;
  assign BUS_GRANT_ACK                = (state == CLBC_GRANT);
  assign INIT_DONE                    = (state != CLBC_INIT);

  // Interrupt sampling and non-maskable edge detection.
  logic nmi_prev, next_nmi_prev, nmi_pend, next_nmi_pend;
  logic [2:0] nmi_low, next_nmi_low, nmi_high, next_nmi_high;
  logic       take, next_take, internal, next_internal;
  logic [7:0] vec, next_vec;
  always_comb begin
    next_nmi_prev = nmi_s;
    next_nmi_low  = (!nmi_s && nmi_low != 3'(CLBC_NMI_LVL_CYC)) ? nmi_low + 3'h1 : (nmi_s ? nmi_low : 3'h1);
    next_nmi_high = nmi_s ? ((nmi_high != 3'(CLBC_NMI_LVL_CYC)) ? nmi_high + 3'h1 : nmi_high) : 3'h0;
    next_nmi_pend = nmi_pend;
    if (!nmi_s)
      next_nmi_low = (nmi_prev) ? 3'h1 : next_nmi_low;
    next_take     = 1'b0;
    next_internal = 1'b0;
    next_vec      = vec;
    if (INSTR_END_NEAR && phase) begin
      if (nmi_pend) begin
        next_take     = 1'b1;
        next_internal = 1'b1;
        next_vec      = CLBC_NMI_VECTOR;
        next_nmi_pend = 1'b0;
      end else if (!err_n_s && WAIT_INSTR) begin
        next_take     = 1'b1;
        next_internal = 1'b1;
        next_vec      = 8'h10;
      end else if (irq_s && INT_ENABLE) begin
        next_take = 1'b1;
      end
    end
    // A new edge in the cycle that services the old one must not be lost, so the set comes last.
    if (nmi_s && nmi_high == 3'(CLBC_NMI_LVL_CYC - 1) && nmi_low == 3'(CLBC_NMI_LVL_CYC))
      next_nmi_pend = 1'b1;
  end
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      nmi_prev <= 1'b0;
      nmi_pend <= 1'b0;
      nmi_low  <= 3'h0;
      nmi_high <= 3'h0;
      take     <= 1'b0;
      internal <= 1'b0;
      vec      <= 8'h00;
    end else begin
      nmi_prev <= next_nmi_prev;
      nmi_pend <= next_nmi_pend;
      nmi_low  <= next_nmi_low;
      nmi_high <= next_nmi_high;
      take     <= next_take;
      internal <= next_internal;
      vec      <= next_vec;
    end
  end
  assign INT_TAKE     = take;
  assign INT_INTERNAL = internal;
  assign INT_VECTOR   = vec;
  // Stall ends on busy high, on an enabled maskable request, or on a pending non-maskable interrupt so the core can service it.
  assign EXEC_STALL   = WAIT_INSTR && !busy_n_s && !(irq_s && INT_ENABLE) && !nmi_pend;

  chk_inta_code: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state == CLBC_IDLE && !hold_s && CYC_REQ && CYC_KIND == CLBC_REQ_INTA) |=>
    (!cod && !mio && !CYCLE_STATUS_HI_N && !CYCLE_STATUS_LO_N)) else $error("bad inta code");
  chk_no_reserved: assert property (@(posedge SYS_CLK) disable iff (RST)
    !({cod, mio, status} inside {4'b0001, 4'b0010, 4'b1000})) else $error("reserved code issued");
  chk_ready_end: assert property (@(posedge SYS_CLK) disable iff (RST)
    (state == CLBC_CMD && ready_n_s) |=> (state == CLBC_CMD)) else $error("cycle ended early");
  chk_grant_float: assert property (@(posedge SYS_CLK) disable iff (RST)
    $rose(BUS_GRANT_ACK) |-> $past(!BUS_DRIVE_OE)) else $error("grant before float");
  chk_grant_hold: assert property (@(posedge SYS_CLK) disable iff (RST)
    BUS_GRANT_ACK |-> (BUS_LOCK_N && CYCLE_STATUS_HI_N && !BUS_LOCK_N_OE)) else $error("lock not floated");
  chk_grant_mio: assert property (@(posedge SYS_CLK) disable iff (RST)
    BUS_GRANT_ACK |-> $stable(mio) && $stable(cod)) else $error("select moved in grant");
  chk_init_len: assert property (@(posedge SYS_CLK) disable iff (RST)
    $rose(INIT_DONE) |-> init_cnt == 6'(CLBC_INIT_CYC)) else $error("init length wrong");
  chk_mask_irq: assert property (@(posedge SYS_CLK) disable iff (RST)
    (take && !internal) |-> $past(INT_ENABLE)) else $error("masked irq taken");
endmodule : clbc_top

// *** clbc_bus_model.sv ***
// Bus controller model that ends each status cycle with ready.
`timescale 1ns/1ps
module clbc_bus_model #(
  parameter int WAITS = 2
) (
  input  wire logic SYS_CLK,
  input  wire logic RST,
  input  wire logic CYCLE_STATUS_HI_N,
  input  wire logic CYCLE_STATUS_LO_N,
  output logic      READY_N
);
  int cnt;
  // Ready is open collector, so between answers the line rests at its pull-up level.
  // It is low for one clock only, so a following cycle never sees a stale answer.
  always @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cnt <= 0;
      READY_N <= 1'b1;
    end else if (cnt == 0) begin
      READY_N <= 1'b1;
      if (!CYCLE_STATUS_HI_N || !CYCLE_STATUS_LO_N) cnt <= 1;
    end else begin
      READY_N <= !(cnt == WAITS + 1);
      cnt <= (cnt == WAITS + 1) ? 0 : cnt + 1;
    end
  end
endmodule : clbc_bus_model

// *** clbc_top_bench.sv ***
// Self-checking bench for the local bus control block.
`timescale 1ns/1ps
module clbc_top_bench;
  import clbc_pkg::*;
  logic SYS_CLK = 0, RST = 0, CYC_REQ = 0, CYC_LOCKED = 0, CYC_OPERAND = 0, INT_ENABLE = 0;
  logic WAIT_INSTR = 0, INSTR_END_NEAR = 0, BUS_REQUEST = 0, MASKABLE_IRQ = 0, NMI_REQUEST = 0;
  logic EXT_OPERAND_REQUEST = 0, COPRO_BUSY_N = 1, COPRO_ERROR_N = 1, READY_N, in_status;
  clbc_req_t CYC_KIND = CLBC_REQ_FETCH;
  logic CYC_DONE, INT_TAKE, INT_INTERNAL, EXEC_STALL, INIT_DONE, ADDR_A1, BUS_DRIVE_OE, BUS_GRANT_ACK;
  logic [7:0] INT_VECTOR;
  logic CYCLE_STATUS_HI_N, CYCLE_STATUS_HI_N_OE, CYCLE_STATUS_LO_N, CYCLE_STATUS_LO_N_OE;
  logic MEM_IO_SELECT, MEM_IO_SELECT_OE, FETCH_OR_INTACK_QUALIFIER, FETCH_OR_INTACK_QUALIFIER_OE;
  logic BUS_LOCK_N, BUS_LOCK_N_OE, EXT_OPERAND_ACK_N, EXT_OPERAND_ACK_N_OE;
  int n_fail = 0, tests_run = 0;
  // Expected {qualifier, select, status hi, status lo} in the order of the request kinds.
  localparam logic [3:0] CODES [8] = '{4'hd, 4'h5, 4'h6, 4'h9, 4'ha, 4'h4, 4'h4, 4'h0};
  assign in_status = !(CYCLE_STATUS_HI_N && CYCLE_STATUS_LO_N);
  clbc_top i_dut (.*);
  clbc_bus_model #(.WAITS(2)) i_bus (
    .SYS_CLK(SYS_CLK), .RST(RST), .CYCLE_STATUS_HI_N(CYCLE_STATUS_HI_N),
    .CYCLE_STATUS_LO_N(CYCLE_STATUS_LO_N), .READY_N(READY_N));
  always #25 SYS_CLK = ~SYS_CLK;
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic tick(input int n = 1);
    repeat (n) @(posedge SYS_CLK);
    #1;
  endtask : tick
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    for (int i = 0; i < lim && sig !== lvl; i++) tick();
    if (sig !== lvl) begin
      n_fail++;
      $display("unexpected at %0t: wait ran out, got %h expected %h", $time, sig, lvl);
      tally_and_finish();
    end
  endtask : wait_for
  task automatic test_reset_init;
    int i;
    check({CYCLE_STATUS_HI_N, CYCLE_STATUS_LO_N, BUS_LOCK_N, EXT_OPERAND_ACK_N, ADDR_A1}, 8'h1f);
    check({MEM_IO_SELECT, FETCH_OR_INTACK_QUALIFIER, BUS_GRANT_ACK}, 8'h00);
    RST = 1'b0;
    for (i = 0; i < 70 && INIT_DONE !== 1'b1; i++) tick();
    check(INIT_DONE, 1'b1);
    check(i >= CLBC_INIT_CYC - 2 && i <= CLBC_INIT_CYC + 2, 1'b1);
    $display("reset and init test done");
  endtask : test_reset_init
  task automatic run_cycle;
    CYC_REQ = 1'b1;
    wait_for(in_status, 1'b1, 10);
    CYC_REQ = 1'b0;
    tick();
    check(in_status, 1'b0);
    wait_for(READY_N, 1'b0, 10);
    check(CYC_DONE, 1'b0);
    wait_for(CYC_DONE, 1'b1, 20);
    tick(2);
  endtask : run_cycle
  task automatic test_cycles;
    for (int k = 0; k < 8; k++) begin
      CYC_KIND = clbc_req_t'(k);
      CYC_REQ = 1'b1;
      wait_for(in_status, 1'b1, 10);
      check({FETCH_OR_INTACK_QUALIFIER, MEM_IO_SELECT, CYCLE_STATUS_HI_N, CYCLE_STATUS_LO_N}, CODES[k]);
      if (k inside {5, 6}) check(ADDR_A1, k == 5);
      check(BUS_LOCK_N, k != 7);
      run_cycle();
    end
    $display("cycle encoding test done");
  endtask : test_cycles
  task automatic test_hold;
    logic [1:0] last;
    CYC_KIND = CLBC_REQ_FETCH;
    run_cycle();
    last = {MEM_IO_SELECT, FETCH_OR_INTACK_QUALIFIER};
    BUS_REQUEST = 1'b1;
    wait_for(BUS_GRANT_ACK, 1'b1, 20);
    check({BUS_DRIVE_OE, CYCLE_STATUS_HI_N_OE, CYCLE_STATUS_LO_N_OE, BUS_LOCK_N_OE, EXT_OPERAND_ACK_N_OE}, 8'h00);
    check({CYCLE_STATUS_HI_N, CYCLE_STATUS_LO_N, BUS_LOCK_N, EXT_OPERAND_ACK_N}, 8'h0f);
    check({MEM_IO_SELECT, FETCH_OR_INTACK_QUALIFIER}, last);
    CYC_REQ = 1'b1;
    tick(8);
    check(in_status, 1'b0);
    BUS_REQUEST = 1'b0;
    wait_for(BUS_GRANT_ACK, 1'b0, 20);
    check(BUS_DRIVE_OE, 1'b1);
    run_cycle();
    $display("hold test done");
  endtask : test_hold
  task automatic test_irq;
    int seen = 0;
    MASKABLE_IRQ = 1'b1;
    INSTR_END_NEAR = 1'b1;
    repeat (20) begin
      tick();
      if (INT_TAKE === 1'b1) seen++;
    end
    check(seen, 0);
    INT_ENABLE = 1'b1;
    wait_for(INT_TAKE, 1'b1, 20);
    check(INT_INTERNAL, 1'b0);
    MASKABLE_IRQ = 1'b0;
    INT_ENABLE = 1'b0;
    tick(6);
    NMI_REQUEST = 1'b1;
    wait_for(INT_TAKE, 1'b1, 20);
    check(INT_VECTOR, CLBC_NMI_VECTOR);
    check(INT_INTERNAL, 1'b1);
    tick(4);
    NMI_REQUEST = 1'b0;
    $display("interrupt test done");
  endtask : test_irq
  task automatic test_stall;
    WAIT_INSTR = 1'b1;
    COPRO_BUSY_N = 1'b0;
    tick(4);
    check(EXEC_STALL, 1'b1);
    COPRO_BUSY_N = 1'b1;
    tick(4);
    check(EXEC_STALL, 1'b0);
    WAIT_INSTR = 1'b0;
    $display("stall test done");
  endtask : test_stall
  task automatic test_copro;
    WAIT_INSTR = 1'b1;
    COPRO_ERROR_N = 1'b0;
    wait_for(INT_TAKE, 1'b1, 20);
    check(INT_VECTOR, 8'h10);
    check(INT_INTERNAL, 1'b1);
    COPRO_ERROR_N = 1'b1;
    WAIT_INSTR = 1'b0;
    tick(4);
    CYC_KIND = CLBC_REQ_MEM_RD;
    CYC_OPERAND = 1'b1;
    CYC_REQ = 1'b1;
    wait_for(in_status, 1'b1, 10);
    check(EXT_OPERAND_ACK_N, 1'b0);
    run_cycle();
    check(EXT_OPERAND_ACK_N, 1'b1);
    CYC_OPERAND = 1'b0;
    $display("coprocessor test done");
  endtask : test_copro
  initial begin
    #1 RST = 1'b1;
    // Reset stays up longer than the minimum width the device demands.
    tick(17);
    test_reset_init();
    test_cycles();
    test_hold();
    test_irq();
    test_stall();
    test_copro();
    tally_and_finish();
  end
endmodule : clbc_top_bench
